//--- common/sp_pkg.sv
/*
 * Constants, types and the tap decode shared by the stepping
 * potentiometer control logic. Assumes a single 250 MHz clock.
 */
package sp_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam int FSCL_MAX_KHZ = 400;
	localparam int GLITCH_NS = 50;
	// Least time: round up to whole cycles
	localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int NV_WRITE_MS = 10;
	localparam int NV_WRITE_MAX_MS = 20;
	localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_MHZ * 1000;

	// ==========================================================
	// Register map and fields
	localparam logic [7:0] REG_WIPER = 8'h00;
	localparam logic [7:0] REG_STEP = 8'h01;
	localparam logic [7:0] REG_MODE = 8'h02;
	localparam logic [6:0] WIPER_RST = 7'h40;
	localparam logic [7:0] STEP_RST = 8'h00;
	localparam logic MODE_RST = 1'b0;
	localparam int MODE_LIVE_ONLY_BIT = 7;
	localparam int SPAN_MSB = 4;
	localparam int SPAN_LSB = 0;
	localparam int PERIOD_MSB = 6;
	localparam int PERIOD_LSB = 5;
	localparam logic [8:0] PERIOD_BASE = 9'h020;
	localparam logic [9:0] INIT_PULSES = 10'h200;
	localparam logic [6:0] SECOND_BASE = 7'h40;
	localparam logic [6:0] CODE_MAX = 7'h7f;

	// Target address: arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h2a;

	// ==========================================================
	// Serial port states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_RACK = 3'b100
	} sp_state_t;

	function automatic logic [127:0] sp_tap(input logic [6:0] code);
		sp_tap = 128'h1 << code;
	endfunction

endpackage

//--- common/sp_pin_if.sv
/*
 * Filtered pin levels and edge pulses between the input
 * conditioner and the control logic. Same clock on both sides.
 */
`timescale 1ns/10ps
interface sp_pin_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_fall;
	logic step_rise;

	modport filt (output scl, sda, scl_rise, scl_fall, sda_rise,
		sda_fall, step_rise);
	modport ctrl (input scl, sda, scl_rise, scl_fall, sda_rise,
		sda_fall, step_rise);
endinterface

//--- design/sp_filter.sv
/*
 * Input conditioner: synchronises the serial clock, serial data and
 * step pulse pins and suppresses short glitches on the serial lines.
 * Assumes the pins are asynchronous to clk_in.
 */
`timescale 1ns/10ps
module sp_filter
	import sp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic step_in,
	sp_pin_if.filt pins
);

	// ==========================================================
	// Serial lines: sync then stability filter
	logic [1:0] raw;
	logic [1:0] lvl;
	logic [1:0] rise;
	logic [1:0] fall;
	assign raw = {sda_in, scl_in};

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_line
			logic s1_r;
			logic s2_r;
			logic filt_r;
			logic [4:0] cnt_r;
			logic rise_r;
			logic fall_r;
			wire differ = s2_r != filt_r;
			wire settled = cnt_r == 5'(GLITCH_CYC - 1);
			always_ff @(posedge clk_in)
			begin
				if (!rst_n_in)
				begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
					filt_r <= 1'b1;
					cnt_r <= 5'h00;
					rise_r <= 1'b0;
					fall_r <= 1'b0;
				end
				else
				begin
					s1_r <= raw[i];
					s2_r <= s1_r;
					// Level must hold a full width before it counts
					cnt_r <= (differ && !settled) ? cnt_r + 5'h01 : 5'h00;
					if (differ && settled)
						filt_r <= s2_r;
					rise_r <= differ && settled && s2_r;
					fall_r <= differ && settled && !s2_r;
				end
			end
			assign lvl[i] = filt_r;
			assign rise[i] = rise_r;
			assign fall[i] = fall_r;
		end
	endgenerate

	assign pins.scl = lvl[0];
	assign pins.sda = lvl[1];
	assign pins.scl_rise = rise[0];
	assign pins.scl_fall = fall[0];
	assign pins.sda_rise = rise[1];
	assign pins.sda_fall = fall[1];

	// ==========================================================
	// Step pulse: sync and rising edge
	logic st1_r;
	logic st2_r;
	logic st3_r;
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			st1_r <= 1'b0;
			st2_r <= 1'b0;
			st3_r <= 1'b0;
		end
		else
		begin
			st1_r <= step_in;
			st2_r <= st1_r;
			st3_r <= st2_r;
		end
	end
	assign pins.step_rise = st2_r && !st3_r;

endmodule

//--- design/sp_pot_top.sv
/*
 * Register control of a two-output stepping potentiometer behind a
 * byte-register serial target port: wiper, step setup and write mode
 * registers, nonvolatile commit timing, stepping and tap decode.
 * Assumes open-drain data resolved outside, pins asynchronous.
 */
`timescale 1ns/10ps
module sp_pot_top
	import sp_pkg::*;
#(
	parameter int NV_CYC = NV_WRITE_CYC
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	input wire logic step_in,
	output logic [127:0] main_tap_out,
	output logic [127:0] second_tap_out,
	output logic nv_busy_out
);

	sp_pin_if pins ();

	sp_filter u_filter (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.step_in(step_in),
		.pins(pins.filt)
	);

	// ==========================================================
	// Registers
	sp_state_t state_r;
	logic [7:0] shreg_r;
	logic [3:0] bit_cnt_r;
	logic [1:0] byte_idx_r;
	logic rw_r;
	logic ack_ok_r;
	logic [7:0] ptr_r;
	logic [7:0] tx_r;
	logic [6:0] wr_r;
	logic [6:0] nv_wiper_r;
	logic [7:0] scr_r;
	logic [7:0] nv_scr_r;
	logic mode_r;
	logic [6:0] stage_wiper_r;
	logic [7:0] stage_scr_r;
	logic pend_wiper_r;
	logic pend_scr_r;
	logic recall_r;
	logic [23:0] nv_cnt_r;
	logic [9:0] init_cnt_r;
	logic [8:0] pc_r;
	logic signed [5:0] count_r;
	logic dir_down_r;

	// ==========================================================
	// Bus decode
	wire start_ev = pins.sda_fall && pins.scl;
	wire stop_ev = pins.sda_rise && pins.scl;
	wire byte_done = state_r == ST_RX && pins.scl_fall && bit_cnt_r == 4'h8;
	wire addr_hit = shreg_r[7:1] == DEV_ADDR;
	// Busy device refuses every transfer, read or write, by not acknowledging its address
	wire addr_ok = addr_hit && !nv_busy_out;
	wire data_wr = byte_done && byte_idx_r == 2'h2;
	wire wr_wiper = data_wr && ptr_r == REG_WIPER;
	wire wr_step = data_wr && ptr_r == REG_STEP;
	wire wr_mode = data_wr && ptr_r == REG_MODE;
	wire nv_done = nv_busy_out && nv_cnt_r == 24'(NV_CYC - 1);
	wire nv_go = stop_ev && (pend_wiper_r || pend_scr_r);
	// Reads always see the live wiper
	wire [7:0] rd_data = ptr_r == REG_WIPER ? {1'b0, wr_r} :
		ptr_r == REG_STEP ? scr_r :
		ptr_r == REG_MODE ? {mode_r, 7'h00} : 8'h00;

	// ==========================================================
	// Serial target state machine
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= ST_IDLE;
			shreg_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			byte_idx_r <= 2'h0;
			rw_r <= 1'b0;
			ack_ok_r <= 1'b0;
			tx_r <= 8'h00;
			sda_oe_n_out <= 1'b1;
		end
		else if (start_ev)
		begin
			state_r <= ST_RX;
			bit_cnt_r <= 4'h0;
			byte_idx_r <= 2'h0;
			sda_oe_n_out <= 1'b1;
		end
		else if (stop_ev)
		begin
			state_r <= ST_IDLE;
			sda_oe_n_out <= 1'b1;
		end
		else
		begin
			case (state_r)
			ST_RX:
			begin
				if (pins.scl_rise && bit_cnt_r != 4'h8)
				begin
					shreg_r <= {shreg_r[6:0], pins.sda};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
				else if (byte_done)
				begin
					if (byte_idx_r == 2'h0 && !addr_ok)
						state_r <= ST_IDLE;
					else
					begin
						state_r <= ST_ACK;
						sda_oe_n_out <= 1'b0;
					end
					if (byte_idx_r == 2'h0)
						rw_r <= shreg_r[0];
				end
			end
			ST_ACK:
			begin
				if (pins.scl_fall)
				begin
					bit_cnt_r <= 4'h0;
					if (byte_idx_r != 2'h2)
						byte_idx_r <= byte_idx_r + 2'h1;
					if (rw_r && byte_idx_r == 2'h0)
					begin
						state_r <= ST_TX;
						tx_r <= rd_data;
						sda_oe_n_out <= rd_data[7];
					end
					else
					begin
						state_r <= ST_RX;
						sda_oe_n_out <= 1'b1;
					end
				end
			end
			ST_TX:
			begin
				if (pins.scl_fall)
				begin
					if (bit_cnt_r == 4'h7)
					begin
						state_r <= ST_RACK;
						sda_oe_n_out <= 1'b1;
					end
					else
					begin
						tx_r <= {tx_r[6:0], 1'b0};
						sda_oe_n_out <= tx_r[6];
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
			end
			ST_RACK:
			begin
				if (pins.scl_rise)
					ack_ok_r <= !pins.sda;
				else if (pins.scl_fall)
				begin
					bit_cnt_r <= 4'h0;
					state_r <= ack_ok_r ? ST_TX : ST_IDLE;
					tx_r <= rd_data;
					sda_oe_n_out <= ack_ok_r ? rd_data[7] : 1'b1;
				end
			end
			default:
			begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ==========================================================
	// Register pointer and register file
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ptr_r <= 8'h00;
		else if (byte_done && byte_idx_r == 2'h1)
			ptr_r <= shreg_r;
		else if (data_wr || (state_r == ST_RACK && pins.scl_fall))
			ptr_r <= ptr_r + 8'h01;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			nv_wiper_r <= WIPER_RST;
			nv_scr_r <= STEP_RST;
			wr_r <= WIPER_RST;
			scr_r <= STEP_RST;
			mode_r <= MODE_RST;
			recall_r <= 1'b1;
			stage_wiper_r <= WIPER_RST;
			stage_scr_r <= STEP_RST;
			pend_wiper_r <= 1'b0;
			pend_scr_r <= 1'b0;
		end
		else
		begin
			recall_r <= 1'b0;
			if (recall_r)
			begin
				wr_r <= nv_wiper_r;
				scr_r <= nv_scr_r;
			end
			else if (wr_wiper)
				wr_r <= shreg_r[6:0];
			else if (wr_step)
				scr_r <= shreg_r;
			if (wr_mode)
				mode_r <= shreg_r[MODE_LIVE_ONLY_BIT];
			// Stored wiper copy only follows in full-write mode; step copy always follows
			if (wr_wiper && !mode_r)
			begin
				stage_wiper_r <= shreg_r[6:0];
				pend_wiper_r <= 1'b1;
			end
			else if (nv_go)
				pend_wiper_r <= 1'b0;
			if (wr_step)
			begin
				stage_scr_r <= shreg_r;
				pend_scr_r <= 1'b1;
			end
			else if (nv_go)
				pend_scr_r <= 1'b0;
			if (nv_done)
			begin
				nv_wiper_r <= stage_wiper_r;
				nv_scr_r <= stage_scr_r;
			end
		end
	end

	// ==========================================================
	// Nonvolatile write timer
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			nv_busy_out <= 1'b0;
			nv_cnt_r <= 24'h000000;
		end
		else if (nv_go && !nv_busy_out)
		begin
			nv_busy_out <= 1'b1;
			nv_cnt_r <= 24'h000000;
		end
		else if (nv_done)
			nv_busy_out <= 1'b0;
		else if (nv_busy_out)
			nv_cnt_r <= nv_cnt_r + 24'h000001;
	end

	// ==========================================================
	// Stepping
	wire [4:0] span = scr_r[SPAN_MSB:SPAN_LSB];
	wire signed [5:0] span_s = $signed({1'b0, span});
	wire [8:0] period = PERIOD_BASE << scr_r[PERIOD_MSB:PERIOD_LSB];
	wire [9:0] init_load = INIT_PULSES + {2'b00, period[8:1]};
	wire reinit = recall_r || wr_wiper || wr_step || wr_mode;
	wire stepping = span != 5'h00 && init_cnt_r == 10'h000;
	wire step_now = pins.step_rise && stepping &&
		pc_r == period - 9'h001;
	wire [6:0] span7 = {2'b00, span};
	wire [6:0] wr_cl = wr_r < span7 ? span7 :
		wr_r > CODE_MAX - span7 ? CODE_MAX - span7 : wr_r;
	// Clamp also holds during the start-up pulses, count is zero then
	wire [6:0] main_code = span != 5'h00 ?
		7'(wr_cl + 7'($signed(count_r))) : wr_r;
	wire [6:0] second_code = SECOND_BASE + 7'($signed(count_r));

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || reinit)
		begin
			init_cnt_r <= rst_n_in ? init_load : 10'h000;
			pc_r <= 9'h000;
			count_r <= 6'sh00;
			dir_down_r <= 1'b0;
		end
		else if (pins.step_rise)
		begin
			if (init_cnt_r != 10'h000)
				init_cnt_r <= init_cnt_r - 10'h001;
			else if (step_now)
			begin
				pc_r <= 9'h000;
				if (!dir_down_r)
				begin
					count_r <= count_r + 6'sh01;
					if (count_r + 6'sh01 >= span_s)
						dir_down_r <= 1'b1;
				end
				else
				begin
					count_r <= count_r - 6'sh01;
					if (count_r - 6'sh01 <= -span_s)
						dir_down_r <= 1'b0;
				end
			end
			else if (stepping)
				pc_r <= pc_r + 9'h001;
		end
	end

	// ==========================================================
	// Tap outputs
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			main_tap_out <= sp_tap(WIPER_RST);
			second_tap_out <= sp_tap(SECOND_BASE);
			sda_out <= 1'b0;
		end
		else
		begin
			main_tap_out <= sp_tap(main_code);
			second_tap_out <= sp_tap(second_code);
			sda_out <= 1'b0;
		end
	end

endmodule

//--- sim/sp_pot_properties.sv
/*
 * Port checker for the potentiometer top.
 * Assumes raw pins and the bench's NV_CYC.
 */
`timescale 1ns/10ps
module sp_pot_properties
#(
	parameter int NV_CYC = 50
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n_out,
	input wire logic step_in,
	input wire logic [127:0] main_tap_out,
	input wire logic [127:0] second_tap_out,
	input wire logic nv_busy_out
);
	localparam logic [127:0] MID = 128'h1 << 64;
	int busy_r;
	int stop_r;
	int step_r;
	logic sda_r;
	logic stp_r;
	// ======
	// Ages of raw pin events, and cycles since the busy output rose
	always_ff @(posedge clk_in)
	begin
		sda_r <= sda_in;
		stp_r <= step_in;
		busy_r <= nv_busy_out ? busy_r + 1 : 0;
		stop_r <= (scl_in && sda_in && !sda_r) ? 0 : stop_r + 1;
		step_r <= (step_in && !stp_r) ? 0 : step_r + 1;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_nv_start;
		$rose(nv_busy_out);
	endsequence
	property p_onehot;
		$onehot(main_tap_out) && $onehot(second_tap_out);
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap not one-hot");
	property p_rst;
		disable iff (1'b0) !rst_n_in |=> main_tap_out == MID &&
			second_tap_out == MID && !nv_busy_out && sda_oe_n_out;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_nv_len;
		$fell(nv_busy_out) |-> busy_r == NV_CYC;
	endproperty
	a_nv_len: assert property (p_nv_len) else $error("write time");
	property p_nv_max;
		nv_busy_out |-> busy_r < NV_CYC;
	endproperty
	a_nv_max: assert property (p_nv_max) else $error("write overrun");
	property p_nv_stop;
		s_nv_start |-> stop_r < 40;
	endproperty
	a_nv_stop: assert property (p_nv_stop) else $error("no stop");
	property p_no_ack;
		nv_busy_out |-> sda_oe_n_out;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack when busy");
	property p_oe_scl;
		$changed(sda_oe_n_out) |-> !scl_in;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("sda moved");
	property p_ack_len;
		$fell(sda_oe_n_out) |-> !sda_oe_n_out [*8] ##0 !sda_out;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("short ack");
	property p_step;
		$changed(second_tap_out) && second_tap_out != MID |-> step_r < 12;
	endproperty
	a_step: assert property (p_step) else $error("step w/o edge");
endmodule

//--- sim/sp_i2c_host.sv
/*
 * Bus controller model for the serial port.
 * Assumes the bench resolves the open-drain line.
 */
`timescale 1ns/10ps
module sp_i2c_host
#(
	parameter int LOW_CYC = 325
)
(
	input wire logic clk_in,
	input wire logic sda_line_in,
	output logic scl_out,
	output logic sda_out
);
	// 1.3 us low, 1.2 us high: 400 kHz
	localparam int HIGH_CYC = 300;
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic start_c();
		sda_out = 1'b1;
		wt(100);
		scl_out = 1'b1;
		wt(HIGH_CYC);
		sda_out = 1'b0;
		wt(HIGH_CYC);
		scl_out = 1'b0;
	endtask
	task automatic stop_c();
		wt(25);
		sda_out = 1'b0;
		wt(HIGH_CYC);
		scl_out = 1'b1;
		wt(HIGH_CYC);
		sda_out = 1'b1;
	endtask
	// Hold after fall so filtered lines never race
	task automatic bt(input logic b, output logic r);
		wt(25);
		sda_out = b;
		wt(LOW_CYC - 25);
		scl_out = 1'b1;
		wt(HIGH_CYC / 2);
		r = sda_line_in;
		wt(HIGH_CYC / 2);
		scl_out = 1'b0;
	endtask
	task automatic tx(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			bt(d[i], r);
		bt(1'b1, a);
	endtask
	task automatic rx(output logic [7:0] d, input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bt(1'b1, d[i]);
		bt(nack, r);
	endtask
endmodule

//--- sim/sp_pot_tb.sv
/*
 * Self-checking bench for the potentiometer top.
 * Assumes a pull-up on the data line.
 */
`timescale 1ns/10ps
module sp_pot_tb
	import sp_pkg::*;
;
	localparam int NV = 50;
	logic clk = 1'b0;
	logic rst_n;
	logic step;
	logic scl;
	logic sda_h;
	logic sda_o;
	logic oe_n;
	logic busy;
	logic a;
	logic [7:0] v;
	logic [127:0] mt;
	logic [127:0] st;
	logic [31:0] seed = 32'h4437;
	int live;
	int exp_q[$];
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	wire logic line = sda_h & (oe_n | sda_o);
	always #2 clk = ~clk;
	sp_pot_top #(.NV_CYC(NV)) DUT (.clk_in(clk), .rst_n_in(rst_n),
		.scl_in(scl), .sda_in(line), .sda_out(sda_o),
		.sda_oe_n_out(oe_n), .step_in(step), .main_tap_out(mt),
		.second_tap_out(st), .nv_busy_out(busy));
	sp_i2c_host host (.clk_in(clk), .sda_line_in(line),
		.scl_out(scl), .sda_out(sda_h));
	// ======
	// Helpers
	function automatic logic [127:0] tap(input int c);
		tap = 128'h1 << c;
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic hdr(input logic [7:0] r);
		host.start_c();
		host.tx({DEV_ADDR, 1'b0}, a);
		check(a, 1'b0);
		host.tx(r, a);
		check(a, 1'b0);
	endtask
	task automatic wr(input logic [7:0] r, input logic [15:0] d, input int n);
		hdr(r);
		if (n == 2)
		begin
			host.tx(d[15:8], a);
			check(a, 1'b0);
		end
		host.tx(d[7:0], a);
		check(a, 1'b0);
		host.stop_c();
	endtask
	task automatic nv(input logic exp);
		int k;
		for (k = 0; k < 40 && busy !== 1'b1; k++)
			@(negedge clk);
		check(busy, exp);
		for (k = 0; k < 200 && busy !== 1'b0; k++)
			@(negedge clk);
		host.wt(325);
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			step = 1'b1;
			host.wt(8);
			step = 1'b0;
			host.wt(8);
		end
		host.wt(10);
	endtask
	// ======
	// Sequence
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 110000)
		begin
			n_fail++;
			$display("Error %0t: timeout", $time);
			give_verdict();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		step = 1'b0;
		host.wt(2);
		rst_n = 1'b1;
		check(mt, tap(64));
		check(st, tap(64));
		host.wt(4);
		host.start_c();
		host.tx({~DEV_ADDR, 1'b0}, a);
		check(a, 1'b1);
		host.stop_c();
		nv(1'b0);
		$display("test reset and address done");
		seed = lfsr(seed);
		live = int'(seed[6:0]);
		wr(REG_WIPER, 16'(live), 1);
		exp_q.push_back(live);
		check(mt, tap(live));
		nv(1'b1);
		hdr(REG_WIPER);
		host.start_c();
		host.tx({DEV_ADDR, 1'b1}, a);
		check(a, 1'b0);
		host.rx(v, 1'b1);
		host.stop_c();
		check(v, 8'(exp_q.pop_front()));
		nv(1'b0);
		$display("test wiper done");
		wr(REG_STEP, 16'h0280, 2);
		live = live < 2 ? 2 : (live > 125 ? 125 : live);
		check(mt, tap(live));
		nv(1'b1);
		wr(REG_WIPER, 16'h0001, 1);
		check(mt, tap(2));
		nv(1'b0);
		$display("test mode done");
		pulse(559);
		check(mt, tap(2));
		check(st, tap(64));
		pulse(1);
		check(mt, tap(3));
		check(st, tap(65));
		$display("test stepping done");
		give_verdict();
	end
endmodule
bind sp_pot_top sp_pot_properties #(.NV_CYC(NV_CYC)) u_prop (.clk_in,
	.rst_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out, .step_in,
	.main_tap_out, .second_tap_out, .nv_busy_out);
